// >>> link_sink_model.sv
`timescale 1ns/1ps
`include "serial_link_tx_consts.vh"
module link_sink_model (
   input  wire               clk,        // clock
   input  wire               rst_n,      // reset, low
   input  wire               hold,       // stall request from bench
   input  wire [`LINK_W-1:0] link_data,  // offered word
   input  wire               link_valid, // word present
   output reg                link_ready  // word taken
);
   reg [`LINK_W-1:0] got [0:63];
   integer           n_got;
   reg [1:0]         ph_r;
   ////////////////////////////////////////////////////////////////
   // ready two cycles of three, so the buffer never drains at full rate
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= 2'd0;
         link_ready <= 1'b0;
         n_got <= 0;
      end else begin
         ph_r <= (ph_r == 2'd2) ? 2'd0 : ph_r + 2'd1;
         link_ready <= !hold && (ph_r != 2'd2);
         if (link_valid && link_ready) begin
            got[n_got[5:0]] <= link_data;
            n_got <= n_got + 1;
         end
      end
   end
endmodule // link_sink_model

// >>> sample_fifo.v
`timescale 1ns/1ps
module sample_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3,
   parameter SLACK = 5
) (
   input  wire             clk,        // system clock
   input  wire             rst_n,      // synchronised reset, low active
   input  wire             clr,        // synchronous flush
   input  wire [WIDTH-1:0] in_data,    // write word
   input  wire             in_valid,   // write strobe
   output reg              in_ready,   // room for SLACK more words
   output reg  [WIDTH-1:0] out_data,   // head word
   output reg              out_valid,  // head word present
   input  wire             out_ready,  // sink takes head word
   output reg  [AW:0]      level       // words held in the array
);
   localparam [AW:0] READY_MAX = DEPTH - SLACK;
   localparam [AW:0] FULL_CNT  = DEPTH;
   localparam [AW-1:0] PTR_ONE = 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   wire            push;
   wire            pop;
   wire [AW:0]     level_nxt;

   // ready runs early by SLACK so words already in flight still fit
   assign push      = in_valid & (level != FULL_CNT);
   assign pop       = (level != {(AW+1){1'b0}}) & (~out_valid | out_ready);
   assign level_nxt = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r  <= {AW{1'b0}};
         rd_ptr_r  <= {AW{1'b0}};
         level     <= {(AW+1){1'b0}};
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end else if (clr) begin
         wr_ptr_r  <= {AW{1'b0}};
         rd_ptr_r  <= {AW{1'b0}};
         level     <= {(AW+1){1'b0}};
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + PTR_ONE;
         end
         if (pop) begin
            rd_ptr_r  <= rd_ptr_r + PTR_ONE;
            out_data  <= mem[rd_ptr_r];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         level    <= level_nxt;
         in_ready <= (level_nxt <= READY_MAX);
      end
   end
endmodule // sample_fifo

// >>> serial_link_transmit_control.v
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "serial_link_tx_consts.vh"
module serial_link_transmit_control (
   input  wire                 ref_clk,           // 100 MHz system clock
   input  wire                 resetn,            // async reset, low active
   input  wire                 wb_cyc_i,          // wishbone cycle
   input  wire                 wb_stb_i,          // wishbone strobe
   input  wire                 wb_we_i,           // wishbone write
   input  wire [`ADR_W-1:0]    wb_adr_i,          // wishbone byte address
   input  wire [3:0]           wb_sel_i,          // wishbone byte enables
   input  wire [31:0]          wb_dat_i,          // wishbone write data
   output reg  [31:0]          wb_dat_o,          // wishbone read data
   output reg                  wb_ack_o,          // wishbone acknowledge
   input  wire [`SAMPLE_W-1:0] sample_data,       // converter sample
   input  wire                 sample_valid,      // converter sample strobe
   output wire                 sample_ready,      // path can take a sample
   input  wire                 mark_pin,          // timestamp pin, async
   input  wire                 sysref_pin,        // sysref pin, async
   output wire [`LINK_W-1:0]   link_data,         // link sample word
   output wire                 link_valid,        // link word present
   input  wire                 link_ready,        // transport takes word
   output reg                  link_reset_n,      // link subsystem reset, low
   output reg                  serdes_power_down, // serializers off
   output reg                  link_clock_enable, // subsystem clock gate
   output reg                  lmfc_boundary,     // multiframe start pulse
   output reg  [1:0]           ila_control_bits   // control bits advertised
);

   ////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////

   reg                  rst_s1_r;
   reg                  rst_n_r;

   reg                  mark_en_r;
   reg                  en_r;
   reg [`MODE_MSB:0]    mode_r;
   reg [`FPM_MSB:0]     fpm_r;
   reg                  cfg_err_r;
   reg                  rsv_err_r;

   reg [1:0]            sync1_r;
   reg [1:0]            sync2_r;
   reg [1:0]            sync3_r;
   reg [1:0]            filt_r;
   wire [1:0]           filt_nxt;
   reg                  sysref_prev_r;
   wire                 sysref_rise;

   reg [`SAMPLE_W-1:0]  pipe_dat_r [0:`ALIGN_STAGES-1];
   reg [`ALIGN_STAGES-1:0] pipe_vld_r;
   wire                 take_sample;
   wire [`LINK_W-1:0]   link_word;
   wire [`FIFO_AW:0]    fifo_level;

   reg [`CNT_W-1:0]     lmfc_cnt_r;
   wire [`CNT_W-1:0]    k_last;
   wire                 mode_64b;

   wire                 bus_req;
   wire                 wr_req;
   wire [9:0]           idx;
   reg [31:0]           rd_nxt;
   reg                  cfg_write;
   reg                  rsv_hit;
   reg                  st_write;
   integer              i;

   ////////////////////////////////////////////////////////////////////
   // helpers
   ////////////////////////////////////////////////////////////////////

   function is_64b66b;
      input [`MODE_MSB:0] mode;
      begin
         is_64b66b = (mode >= `MODE_64B_FIRST);
      end
   endfunction

   // frames per multiframe minus one from 256*E/F, E and F from the mode
   function [`CNT_W-1:0] mode_k_last;
      input [`MODE_MSB:0] mode;
      reg [`CNT_W:0] k;
      reg [`CNT_W:0] km;
      begin
         k = (mode[2] ? 11'h200 : 11'h100) >> mode[1:0];
         km = k - 11'h001;
         mode_k_last = km[`CNT_W-1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // reset release
   ////////////////////////////////////////////////////////////////////

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: bit 0 mark, bit 1 sysref
   ////////////////////////////////////////////////////////////////////

   // a level changes only once stages two and three agree
   assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         sync3_r <= 2'h0;
         filt_r  <= 2'h0;
      end else begin
         sync1_r <= {sysref_pin, mark_pin};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r  <= filt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sample path
   ////////////////////////////////////////////////////////////////////

   // samples wait as many cycles as the mark spends in its synchroniser
   assign take_sample = sample_valid & sample_ready & en_r;

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pipe_vld_r <= {`ALIGN_STAGES{1'b0}};
         for (i = 0; i < `ALIGN_STAGES; i = i + 1) begin
            pipe_dat_r[i] <= {`SAMPLE_W{1'b0}};
         end
      end else if (!en_r) begin
         pipe_vld_r <= {`ALIGN_STAGES{1'b0}};
      end else begin
         pipe_vld_r <= {pipe_vld_r[`ALIGN_STAGES-2:0], take_sample};
         pipe_dat_r[0] <= sample_data;
         for (i = 1; i < `ALIGN_STAGES; i = i + 1) begin
            pipe_dat_r[i] <= pipe_dat_r[i-1];
         end
      end
   end

   // sample keeps every bit; mark sits in the lsb of the wider field
   assign link_word = {pipe_dat_r[`ALIGN_STAGES-1],
                       {(`LINK_W-`SAMPLE_W-1){1'b0}},
                       filt_r[0] & mark_en_r};

   sample_fifo #(
      .WIDTH (`LINK_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW),
      .SLACK (`FIFO_SLACK)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n_r),
      .clr       (~en_r),
      .in_data   (link_word),
      .in_valid  (pipe_vld_r[`ALIGN_STAGES-1]),
      .in_ready  (sample_ready),
      .out_data  (link_data),
      .out_valid (link_valid),
      .out_ready (link_ready),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////
   // multiframe counter
   ////////////////////////////////////////////////////////////////////

   assign mode_64b    = is_64b66b(mode_r);
   assign k_last      = mode_64b ? mode_k_last(mode_r) : {2'h0, fpm_r};
   assign sysref_rise = filt_r[1] & ~sysref_prev_r;

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         lmfc_cnt_r    <= {`CNT_W{1'b0}};
         lmfc_boundary <= 1'b0;
         sysref_prev_r <= 1'b0;
      end else begin
         sysref_prev_r <= filt_r[1];
         if (!en_r) begin
            lmfc_cnt_r    <= {`CNT_W{1'b0}};
            lmfc_boundary <= 1'b0;
         end else if (sysref_rise || lmfc_cnt_r >= k_last) begin
            lmfc_cnt_r    <= {`CNT_W{1'b0}};
            lmfc_boundary <= 1'b1;
         end else begin
            lmfc_cnt_r    <= lmfc_cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
            lmfc_boundary <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // subsystem controls
   ////////////////////////////////////////////////////////////////////

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         link_reset_n      <= 1'b0;
         serdes_power_down <= 1'b1;
         link_clock_enable <= 1'b0;
         ila_control_bits  <= 2'h0;
      end else begin
         link_reset_n      <= en_r;
         serdes_power_down <= ~en_r;
         link_clock_enable <= en_r;
         ila_control_bits  <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone slave
   ////////////////////////////////////////////////////////////////////

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req  = bus_req & wb_we_i & wb_sel_i[0];
   assign idx     = wb_adr_i[`ADR_W-1:2];

   // config touched while running, reserved bits set: flagged; the config is still stored, reserved bits never are
   always @* begin
      cfg_write = 1'b0;
      rsv_hit   = 1'b0;
      st_write  = 1'b0;
      if (wr_req) begin
         if (idx == `IDX_MARK_CTRL) begin
            rsv_hit = (wb_dat_i[7:1] != 7'h00);
         end else if (idx == `IDX_SUBSYS_EN) begin
            rsv_hit = (wb_dat_i[7:1] != 7'h00);
         end else if (idx == `IDX_OUT_MODE) begin
            rsv_hit   = (wb_dat_i[7:6] != 2'h0);
            cfg_write = en_r;
         end else if (idx == `IDX_FPM) begin
            cfg_write = en_r;
         end else if (idx == `IDX_STATUS) begin
            st_write = 1'b1;
         end
      end
   end

   always @* begin
      rd_nxt = 32'h0000_0000;
      if (idx == `IDX_MARK_CTRL) begin
         rd_nxt[`BIT_MARK_EN] = mark_en_r;
      end else if (idx == `IDX_SUBSYS_EN) begin
         rd_nxt[`BIT_SUBSYS_EN] = en_r;
      end else if (idx == `IDX_OUT_MODE) begin
         rd_nxt[`MODE_MSB:0] = mode_r;
      end else if (idx == `IDX_FPM) begin
         rd_nxt[`FPM_MSB:0] = fpm_r;
      end else if (idx == `IDX_STATUS) begin
         rd_nxt[`ST_EN_BIT]  = en_r;
         rd_nxt[`ST_64B_BIT] = mode_64b;
         rd_nxt[`ST_CFG_BIT] = cfg_err_r;
         rd_nxt[`ST_RSV_BIT] = rsv_err_r;
         rd_nxt[`ST_CNT_LSB+`CNT_W-1:`ST_CNT_LSB] = lmfc_cnt_r;
         rd_nxt[`ST_LVL_LSB+`FIFO_AW:`ST_LVL_LSB] = fifo_level;
      end
   end

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_nxt : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register file
   ////////////////////////////////////////////////////////////////////

   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mark_en_r <= `RST_MARK_EN;
         en_r      <= `RST_SUBSYS_EN;
         mode_r    <= `RST_OUT_MODE;
         fpm_r     <= `RST_FPM;
      end else if (wr_req) begin
         if (idx == `IDX_MARK_CTRL) begin
            mark_en_r <= wb_dat_i[`BIT_MARK_EN];
         end else if (idx == `IDX_SUBSYS_EN) begin
            en_r <= wb_dat_i[`BIT_SUBSYS_EN];
         end else if (idx == `IDX_OUT_MODE) begin
            mode_r <= wb_dat_i[`MODE_MSB:0];
         end else if (idx == `IDX_FPM) begin
            fpm_r <= wb_dat_i[`FPM_MSB:0];
         end
      end
   end

   // sticky flags clear on a write of one; a new event wins over the clear
   always @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_err_r <= 1'b0;
         rsv_err_r <= 1'b0;
      end else begin
         if (cfg_write) begin
            cfg_err_r <= 1'b1;
         end else if (st_write && wb_dat_i[`ST_CFG_BIT]) begin
            cfg_err_r <= 1'b0;
         end
         if (rsv_hit) begin
            rsv_err_r <= 1'b1;
         end else if (st_write && wb_dat_i[`ST_RSV_BIT]) begin
            rsv_err_r <= 1'b0;
         end
      end
   end

endmodule // serial_link_transmit_control

// >>> serial_link_transmit_control_checker.sv
`timescale 1ns/1ps
`include "serial_link_tx_consts.vh"
module serial_link_transmit_control_checker (
   input wire                 ref_clk,           // clock
   input wire                 resetn,            // reset, low
   input wire                 wb_cyc_i,          // bus
   input wire                 wb_stb_i,          // bus
   input wire                 wb_we_i,           // bus
   input wire [`ADR_W-1:0]    wb_adr_i,          // bus
   input wire [3:0]           wb_sel_i,          // bus
   input wire [31:0]          wb_dat_i,          // bus
   input wire [31:0]          wb_dat_o,          // bus
   input wire                 wb_ack_o,          // bus
   input wire [`SAMPLE_W-1:0] sample_data,       // samples
   input wire                 sample_valid,      // samples
   input wire                 sample_ready,      // samples
   input wire                 mark_pin,          // pin
   input wire                 sysref_pin,        // pin
   input wire [`LINK_W-1:0]   link_data,         // link
   input wire                 link_valid,        // link
   input wire                 link_ready,        // link
   input wire                 link_reset_n,      // control
   input wire                 serdes_power_down, // control
   input wire                 link_clock_enable, // control
   input wire                 lmfc_boundary,     // control
   input wire [1:0]           ila_control_bits   // control
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence en_wr_s(logic v);
      take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h800 && wb_dat_i[0] == v);
   endsequence
   ////////////////////////////////////////////////////////////////
   AST_ACK_ANSWER: assert property (take_s |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_RD_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   AST_ILA_ZERO: assert property (ila_control_bits == 2'b00)
      else $error("ila control bits not zero");
   AST_DIS_OUTS: assert property (link_reset_n == link_clock_enable && serdes_power_down == !link_clock_enable)
      else $error("reset, power and clock gate disagree");
   AST_DIS_FLUSH: assert property (!link_clock_enable [*2] |-> !link_valid && !sample_ready)
      else $error("data path active while disabled");
   AST_DIS_LMFC: assert property (!link_clock_enable [*2] |-> !lmfc_boundary)
      else $error("boundary while disabled");
   AST_GAP_BITS: assert property (link_valid |-> link_data[3:1] == 3'b000)
      else $error("pad bits not zero");
   AST_HOLD: assert property (link_valid && !link_ready && link_clock_enable
      |=> !link_clock_enable || (link_valid && $stable(link_data)))
      else $error("link word changed before taken");
   AST_EN_OFF: assert property (en_wr_s(1'b0) |-> ##[1:3] !link_clock_enable)
      else $error("clear of enable had no effect");
   AST_EN_ON: assert property (en_wr_s(1'b1) |-> ##[1:3] link_clock_enable)
      else $error("set of enable had no effect");
endmodule // serial_link_transmit_control_checker
bind serial_link_transmit_control serial_link_transmit_control_checker chk (
   .ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .sample_data, .sample_valid, .sample_ready, .mark_pin, .sysref_pin, .link_data, .link_valid, .link_ready,
   .link_reset_n, .serdes_power_down, .link_clock_enable, .lmfc_boundary, .ila_control_bits);

// >>> serial_link_tx_consts.vh
`ifndef SERIAL_LINK_TX_CONSTS_VH
`define SERIAL_LINK_TX_CONSTS_VH
// Contract
// - mark enable puts mark on link word lsb
// - mark latency equals sample latency
// - mark in wide field lsb, sample intact
// - initial lane alignment control bits always zero
// - subsystem enable bit, resets to one
// - disabled: reset, serializers down, clocks gated
// - disabled: frame counter reset, sysref ignored
// - six-bit output mode field, resets zero
// - frames per multiframe minus one, 0x1f
// - 64b/66b modes use 256*E/F instead

// register indices; byte address is four times the index
`define IDX_MARK_CTRL   10'h160
`define IDX_SUBSYS_EN   10'h200
`define IDX_OUT_MODE    10'h201
`define IDX_FPM         10'h202
`define IDX_STATUS      10'h210
`define ADR_W           12

// reset values at field width
`define RST_MARK_EN     1'b0
`define RST_SUBSYS_EN   1'b1
`define RST_OUT_MODE    6'h00
`define RST_FPM         8'h1f

// field positions
`define BIT_MARK_EN     0
`define BIT_SUBSYS_EN   0
`define MODE_MSB        5
`define FPM_MSB         7
`define ST_EN_BIT       0
`define ST_64B_BIT      1
`define ST_CFG_BIT      2
`define ST_RSV_BIT      3
`define ST_CNT_LSB      8
`define ST_LVL_LSB      20

// mode classes: codes from here up use the 64b/66b link layer
`define MODE_64B_FIRST  6'h10

// data path
`define SAMPLE_W        12
`define LINK_W          16
`define FIFO_DEPTH      8
`define FIFO_AW         3
`define FIFO_SLACK      5
`define ALIGN_STAGES    4
`define CNT_W           10
`endif

// >>> testbench.sv
`timescale 1ns/1ps
`include "serial_link_tx_consts.vh"
module testbench;
   reg                  ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, sample_valid, mark_pin, sysref_pin, hold;
   reg  [`ADR_W-1:0]    wb_adr_i;
   reg  [3:0]           wb_sel_i;
   reg  [31:0]          wb_dat_i, rd;
   reg  [`SAMPLE_W-1:0] sample_data;
   reg  [`LINK_W-1:0]   exp_w [0:31];
   wire [31:0]          wb_dat_o;
   wire [`LINK_W-1:0]   link_data;
   wire [1:0]           ila_control_bits;
   wire                 wb_ack_o, sample_ready, link_valid, link_ready;
   wire                 link_reset_n, serdes_power_down, link_clock_enable, lmfc_boundary;
   integer              n_fail, n_checks;
   serial_link_transmit_control DUT (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_data, .sample_valid, .sample_ready, .mark_pin, .sysref_pin,
      .link_data, .link_valid, .link_ready, .link_reset_n, .serdes_power_down, .link_clock_enable,
      .lmfc_boundary, .ila_control_bits);
   link_sink_model sink (.clk(ref_clk), .rst_n(resetn), .hold, .link_data, .link_valid, .link_ready);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task timeout;
      begin
         n_fail = n_fail + 1;
         $display("wait limit reached at %0t", $time);
         finish_test;
      end
   endtask
   // request held until ack is sampled; bus idles one cycle after
   task wb(input we, input [`ADR_W-1:0] adr, input [31:0] dat, input [3:0] sel);
      integer k;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= dat;
         wb_sel_i <= sel;
         k = 0;
         do begin
            @(posedge ref_clk);
            k = k + 1;
         end while (wb_ack_o !== 1'b1 && k < 20);
         if (wb_ack_o !== 1'b1) timeout;
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task wr(input [`ADR_W-1:0] adr, input [31:0] dat);
      wb(1'b1, adr, dat, 4'hf);
   endtask
   task rdc(input [`ADR_W-1:0] adr, input [31:0] exp);
      begin
         wb(1'b0, adr, 32'h0000_0000, 4'hf);
         check(rd, exp);
      end
   endtask
   task period(output integer p);
      integer k;
      begin
         k = 0;
         while (lmfc_boundary !== 1'b1 && k < 600) begin
            @(posedge ref_clk);
            k = k + 1;
         end
         if (lmfc_boundary !== 1'b1) timeout;
         p = 0;
         do begin
            @(posedge ref_clk);
            p = p + 1;
         end while (lmfc_boundary !== 1'b1 && p < 600);
         if (lmfc_boundary !== 1'b1) timeout;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_regs;
      begin
         rdc(12'h580, 32'h0000_0000);
         rdc(12'h800, 32'h0000_0001);
         rdc(12'h804, 32'h0000_0000);
         rdc(12'h808, 32'h0000_001f);
         wr(12'h800, 32'h0000_00fe);
         rdc(12'h800, 32'h0000_0000);
         wr(12'h804, 32'h0000_00ff);
         rdc(12'h804, 32'h0000_003f);
         wb(1'b1, 12'h804, 32'h0000_0005, 4'he);
         rdc(12'h804, 32'h0000_003f);
         wr(12'h580, 32'h0000_00ff);
         rdc(12'h580, 32'h0000_0001);
         wr(12'h808, 32'h0000_00a5);
         rdc(12'h808, 32'h0000_00a5);
         rdc(12'h840, 32'h0000_000a);
         wr(12'h840, 32'h0000_0008);
         rdc(12'h840, 32'h0000_0002);
         wr(12'h8fc, 32'h0000_0055);
         rdc(12'h8fc, 32'h0000_0000);
         wr(12'h580, 32'h0000_0000);
         $display("t_regs done");
      end
   endtask
   task t_disable;
      integer k, hits;
      begin
         check({28'h0, link_reset_n, serdes_power_down, link_clock_enable, sample_ready}, 32'h0000_0004);
         sysref_pin <= 1'b1;
         hits = 0;
         for (k = 0; k < 12; k = k + 1) begin
            @(posedge ref_clk);
            if (lmfc_boundary === 1'b1) hits = hits + 1;
         end
         sysref_pin <= 1'b0;
         check(hits, 0);
         wb(1'b0, 12'h840, 32'h0000_0000, 4'hf);
         check(rd & 32'h0003_ff01, 32'h0000_0000);
         $display("t_disable done");
      end
   endtask
   // configuration only while disabled
   task run_k(input [31:0] mode, input [31:0] fpm, input integer exp);
      integer p;
      begin
         wr(12'h800, 32'h0000_0000);
         wr(12'h804, mode);
         wr(12'h808, fpm);
         wr(12'h800, 32'h0000_0001);
         period(p);
         check(p, exp);
         $display("run_k done");
      end
   endtask
   task t_sysref;
      integer k;
      begin
         period(k);
         repeat (40) @(posedge ref_clk);
         sysref_pin <= 1'b1;
         k = 0;
         do begin
            @(posedge ref_clk);
            k = k + 1;
         end while (lmfc_boundary !== 1'b1 && k < 20);
         if (lmfc_boundary !== 1'b1) timeout;
         check(k >= 3 && k <= 8, 1);
         sysref_pin <= 1'b0;
         period(k);
         check(k, 256);
         wr(12'h808, 32'h0000_0003);
         wb(1'b0, 12'h840, 32'h0000_0000, 4'hf);
         check(rd & 32'h0000_000f, 32'h0000_0007);
         $display("t_sysref done");
      end
   endtask
   task send(input integer base, input integer n, input en, input pin_hi, output reg refused);
      integer i, k;
      reg     mp;
      reg [`SAMPLE_W-1:0] s;
      begin
         refused = 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            s = 12'h9c3 ^ (i[11:0] * 12'h053);
            mp = pin_hi | ((i / 3) % 2 == 1);
            exp_w[base + i] = {s, 3'b000, mp & en};
            sample_data <= s;
            mark_pin <= mp;
            sample_valid <= 1'b1;
            k = 0;
            do begin
               @(posedge ref_clk);
               k = k + 1;
               if (sample_ready !== 1'b1) refused = 1'b1;
            end while (sample_ready !== 1'b1 && k < 100);
            if (k >= 100) timeout;
         end
         sample_valid <= 1'b0;
         k = 0;
         while (sink.n_got < base + n && k < 300) begin
            @(posedge ref_clk);
            k = k + 1;
         end
         if (k >= 300) timeout;
         for (i = 0; i < n; i = i + 1) check(sink.got[base + i], exp_w[base + i]);
         repeat (3) @(posedge ref_clk);
         check({31'h0, link_valid}, 32'h0000_0000);
      end
   endtask
   task t_stream;
      reg refused;
      begin
         wr(12'h580, 32'h0000_0001);
         hold <= 1'b1;
         fork
            begin
               repeat (30) @(posedge ref_clk);
               hold <= 1'b0;
            end
         join_none
         send(0, 24, 1'b1, 1'b0, refused);
         check({31'h0, refused}, 32'h0000_0001);
         wr(12'h580, 32'h0000_0000);
         send(24, 6, 1'b0, 1'b1, refused);
         $display("t_stream done");
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      n_checks = 0;
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, sample_valid, mark_pin, sysref_pin, hold} = 8'h00;
      wb_adr_i = 12'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      sample_data = 12'h000;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs;
      t_disable;
      run_k(32'h0000_0000, 32'h0000_0003, 4);
      run_k(32'h0000_0000, 32'h0000_001f, 32);
      run_k(32'h0000_0013, 32'h0000_0003, 32);
      run_k(32'h0000_0016, 32'h0000_0003, 128);
      run_k(32'h0000_0010, 32'h0000_0003, 256);
      t_sysref;
      t_stream;
      finish_test;
   end
endmodule // testbench
